// [pswf_pkg.sv]
// Summary of operation
// RULE1: add or subtract sets carry_flag on carry out of or borrow into bit 7
// RULE2: multiply and divide always clear carry_flag
// RULE3: decimal adjust sets carry_flag when adjusted sum reaches 100
// RULE4: compare sets carry_flag when unsigned first operand is smaller
// RULE5: half_carry_flag follows carry or borrow at the low nibble
// RULE6: user_flag_zero and user_flag_one change only by software writes
// RULE7: bank select bits map working registers onto one of four 8-byte banks
// RULE8: add sets signed_wrap_flag when carries out of bits 6 and 7 differ
// RULE9: subtract sets signed_wrap_flag when borrows into bits 6 and 7 differ
// RULE10: multiply sets signed_wrap_flag when the product exceeds 255
// RULE11: divide clears signed_wrap_flag, sets it when the divisor is zero
// RULE12: parity bit tracks odd count of ones in the accumulator, read-only
// RULE13: status word sits at D0H and clears to all zeros on reset
// RULE14: software write updates writable bits, parity ignores written data
package pswf_pkg;

  localparam int          PSWF_ADDR_W     = 12;
  localparam logic [11:0] PSWF_ADDR_PSW   = 12'h0D0;
  localparam logic [7:0]  PSWF_RESET      = 8'h00;

  localparam int          PSWF_BIT_CY     = 7;
  localparam int          PSWF_BIT_AC     = 6;
  localparam int          PSWF_BIT_F0     = 5;
  localparam int          PSWF_BIT_RS1    = 4;
  localparam int          PSWF_BIT_RS0    = 3;
  localparam int          PSWF_BIT_OV     = 2;
  localparam int          PSWF_BIT_F1     = 1;
  localparam int          PSWF_BIT_P      = 0;

  localparam logic [3:0]  PSWF_BCD_MAX    = 4'h9;
  localparam logic [8:0]  PSWF_DA_LO_ADJ  = 9'h006;
  localparam logic [8:0]  PSWF_DA_HI_ADJ  = 9'h060;
  localparam logic [15:0] PSWF_MUL_LIMIT  = 16'h00FF;
  localparam logic [7:0]  PSWF_DIV_ZERO   = 8'h00;
  localparam int          PSWF_BANK_SHIFT = 3;

  typedef enum logic [2:0]
  {
    PSWF_OP_NONE = 3'h0,
    PSWF_OP_ADD  = 3'h1,
    PSWF_OP_ADDC = 3'h3,
    PSWF_OP_SUBB = 3'h2,
    PSWF_OP_MUL  = 3'h6,
    PSWF_OP_DIV  = 3'h7,
    PSWF_OP_DA   = 3'h5,
    PSWF_OP_CJNE = 3'h4
  } pswf_op_t;

endpackage : pswf_pkg

// [pswf_bank_map.sv]
`timescale 1ns/1ps
module pswf_bank_map
(
  input  wire logic [1:0] i_bank,
  input  wire logic [2:0] i_reg_idx,
  output logic      [7:0] o_ram_addr
);

  // bank base is bank times eight, register index selects the byte
  assign o_ram_addr = {3'h0, i_bank, i_reg_idx}; // [RULE7]

endmodule : pswf_bank_map

// [pswf_status_word.sv]
`timescale 1ns/1ps
module pswf_status_word
(
  input  wire logic                           i_clk,
  input  wire logic                           i_rstn,
  input  wire logic                           i_psel,
  input  wire logic                           i_penable,
  input  wire logic                           i_pwrite,
  input  wire logic [pswf_pkg::PSWF_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]                    i_pwdata,
  input  wire logic [3:0]                     i_pstrb,
  output logic      [31:0]                    o_prdata,
  output logic                                o_pready,
  output logic                                o_pslverr,
  input  wire logic                           i_op_valid,
  input  wire pswf_pkg::pswf_op_t             i_op_kind,
  input  wire logic [7:0]                     i_op_a,
  input  wire logic [7:0]                     i_op_b,
  input  wire logic                           i_bit_we,
  input  wire logic [2:0]                     i_bit_sel,
  input  wire logic                           i_bit_val,
  input  wire logic [7:0]                     i_acc,
  input  wire logic [2:0]                     i_reg_idx,
  output logic                                o_carry_flag,
  output logic                                o_half_carry_flag,
  output logic                                o_user_flag_zero,
  output logic                                o_bank_select_hi,
  output logic                                o_bank_select_lo,
  output logic                                o_signed_wrap_flag,
  output logic                                o_user_flag_one,
  output logic                                o_parity,
  output logic      [7:0]                     o_ram_addr
);

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic       hit;
  logic       apb_wr;
  logic [7:0] status_word;
  logic [7:0] map_addr;

  assign hit    = (i_paddr == pswf_pkg::PSWF_ADDR_PSW); // [RULE13]
  assign apb_wr = i_psel && i_penable && o_pready && i_pwrite && hit
                  && i_pstrb[0];

  assign status_word = {o_carry_flag, o_half_carry_flag, o_user_flag_zero,
                        o_bank_select_hi, o_bank_select_lo,
                        o_signed_wrap_flag, o_user_flag_one, o_parity};

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end
    else
    begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !hit;
      if (i_psel && !i_penable)
        o_prdata <= hit ? {24'h00_0000, status_word} : 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flag computation

  logic       cin;
  logic [8:0] sum9;
  logic [4:0] sum_lo;
  logic [7:0] sum_b6;
  logic [8:0] dif9;
  logic [4:0] dif_lo;
  logic [7:0] dif_b6;
  logic [15:0] prod;
  logic [8:0] da_t1;
  logic [8:0] da_t2;
  logic       next_cy;
  logic       next_ac;
  logic       next_ov;
  logic       upd_cy;
  logic       upd_ac;
  logic       upd_ov;

  assign cin    = (i_op_kind == pswf_pkg::PSWF_OP_NONE) ? 1'b0 :
                  (i_op_kind == pswf_pkg::PSWF_OP_ADD)  ? 1'b0 : o_carry_flag;
  assign sum9   = {1'b0, i_op_a} + {1'b0, i_op_b} + {8'h00, cin};
  assign sum_lo = {1'b0, i_op_a[3:0]} + {1'b0, i_op_b[3:0]} + {4'h0, cin};
  assign sum_b6 = {1'b0, i_op_a[6:0]} + {1'b0, i_op_b[6:0]} + {7'h00, cin};
  assign dif9   = {1'b0, i_op_a} - {1'b0, i_op_b} - {8'h00, cin};
  assign dif_lo = {1'b0, i_op_a[3:0]} - {1'b0, i_op_b[3:0]} - {4'h0, cin};
  assign dif_b6 = {1'b0, i_op_a[6:0]} - {1'b0, i_op_b[6:0]} - {7'h00, cin};
  assign prod   = {8'h00, i_op_a} * {8'h00, i_op_b};

  always_comb
  begin
    da_t1 = {1'b0, i_op_a};
    if ((i_op_a[3:0] > pswf_pkg::PSWF_BCD_MAX) || o_half_carry_flag)
      da_t1 = {1'b0, i_op_a} + pswf_pkg::PSWF_DA_LO_ADJ;
    da_t2 = da_t1;
    if ((da_t1[7:4] > pswf_pkg::PSWF_BCD_MAX) || da_t1[8] || o_carry_flag)
      da_t2 = da_t1 + pswf_pkg::PSWF_DA_HI_ADJ;
  end

  always_comb
  begin
    next_cy = o_carry_flag;
    next_ac = o_half_carry_flag;
    next_ov = o_signed_wrap_flag;
    upd_cy  = 1'b0;
    upd_ac  = 1'b0;
    upd_ov  = 1'b0;
    case (i_op_kind)
      pswf_pkg::PSWF_OP_ADD,
      pswf_pkg::PSWF_OP_ADDC:
      begin
        next_cy = sum9[8]; // [RULE1]
        next_ac = sum_lo[4]; // [RULE5]
        next_ov = sum_b6[7] ^ sum9[8]; // [RULE8]
        upd_cy  = 1'b1;
        upd_ac  = 1'b1;
        upd_ov  = 1'b1;
      end
      pswf_pkg::PSWF_OP_SUBB:
      begin
        next_cy = dif9[8]; // [RULE1]
        next_ac = dif_lo[4]; // [RULE5]
        next_ov = dif_b6[7] ^ dif9[8]; // [RULE9]
        upd_cy  = 1'b1;
        upd_ac  = 1'b1;
        upd_ov  = 1'b1;
      end
      pswf_pkg::PSWF_OP_MUL:
      begin
        next_cy = 1'b0; // [RULE2]
        next_ov = prod > pswf_pkg::PSWF_MUL_LIMIT; // [RULE10]
        upd_cy  = 1'b1;
        upd_ov  = 1'b1;
      end
      pswf_pkg::PSWF_OP_DIV:
      begin
        next_cy = 1'b0; // [RULE2]
        next_ov = (i_op_b == pswf_pkg::PSWF_DIV_ZERO); // [RULE11]
        upd_cy  = 1'b1;
        upd_ov  = 1'b1;
      end
      pswf_pkg::PSWF_OP_DA:
      begin
        next_cy = da_t2[8] || da_t1[8] || o_carry_flag; // [RULE3]
        upd_cy  = 1'b1;
      end
      pswf_pkg::PSWF_OP_CJNE:
      begin
        next_cy = (i_op_a < i_op_b); // [RULE4]
        upd_cy  = 1'b1;
      end
      default:
      begin
        next_cy = o_carry_flag;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // write value: apb word, then bit write, then instruction result

  logic [7:0] wr_val;
  logic       wr_any;

  always_comb
  begin
    wr_val = status_word;
    wr_any = 1'b0;
    if (apb_wr)
    begin
      wr_val = i_pwdata[7:0]; // [RULE14]
      wr_any = 1'b1;
    end
    if (i_bit_we)
    begin
      wr_val[i_bit_sel] = i_bit_val;
      wr_any = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // arithmetic flags

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_carry_flag       <= pswf_pkg::PSWF_RESET[pswf_pkg::PSWF_BIT_CY];
      o_half_carry_flag  <= pswf_pkg::PSWF_RESET[pswf_pkg::PSWF_BIT_AC];
      o_signed_wrap_flag <= pswf_pkg::PSWF_RESET[pswf_pkg::PSWF_BIT_OV];
    end
    else
    begin
      if (i_op_valid && upd_cy)
        o_carry_flag <= next_cy;
      else if (wr_any)
        o_carry_flag <= wr_val[pswf_pkg::PSWF_BIT_CY];
      if (i_op_valid && upd_ac)
        o_half_carry_flag <= next_ac;
      else if (wr_any)
        o_half_carry_flag <= wr_val[pswf_pkg::PSWF_BIT_AC];
      if (i_op_valid && upd_ov)
        o_signed_wrap_flag <= next_ov;
      else if (wr_any)
        o_signed_wrap_flag <= wr_val[pswf_pkg::PSWF_BIT_OV];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software-only bits

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_user_flag_zero <= pswf_pkg::PSWF_RESET[pswf_pkg::PSWF_BIT_F0];
      o_user_flag_one  <= pswf_pkg::PSWF_RESET[pswf_pkg::PSWF_BIT_F1];
      o_bank_select_hi <= pswf_pkg::PSWF_RESET[pswf_pkg::PSWF_BIT_RS1];
      o_bank_select_lo <= pswf_pkg::PSWF_RESET[pswf_pkg::PSWF_BIT_RS0];
    end
    else if (wr_any)
    begin
      o_user_flag_zero <= wr_val[pswf_pkg::PSWF_BIT_F0]; // [RULE6]
      o_user_flag_one  <= wr_val[pswf_pkg::PSWF_BIT_F1]; // [RULE6]
      o_bank_select_hi <= wr_val[pswf_pkg::PSWF_BIT_RS1];
      o_bank_select_lo <= wr_val[pswf_pkg::PSWF_BIT_RS0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // parity and bank address

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_parity <= pswf_pkg::PSWF_RESET[pswf_pkg::PSWF_BIT_P];
    else
      o_parity <= ^i_acc; // [RULE12] [RULE14]
  end

  pswf_bank_map u_bank_map
  (
    .i_bank     ({o_bank_select_hi, o_bank_select_lo}),
    .i_reg_idx  (i_reg_idx),
    .o_ram_addr (map_addr)
  );

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_ram_addr <= 8'h00;
    else
      o_ram_addr <= map_addr; // [RULE7]
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_op(pswf_pkg::pswf_op_t k);
    i_op_valid && (i_op_kind == k);
  endsequence

  sequence s_no_write;
    !apb_wr && !i_bit_we;
  endsequence

  property p_add_carry;
    s_op(pswf_pkg::PSWF_OP_ADD) |=> o_carry_flag ==
      (({1'b0, $past(i_op_a)} + {1'b0, $past(i_op_b)}) > 9'h0FF);
  endproperty
  a_add_carry: assert property (p_add_carry) // [RULE1]
    else $error("carry wrong after add");

  property p_muldiv_carry;
    (s_op(pswf_pkg::PSWF_OP_MUL) or s_op(pswf_pkg::PSWF_OP_DIV))
      |=> !o_carry_flag;
  endproperty
  a_muldiv_carry: assert property (p_muldiv_carry) // [RULE2]
    else $error("carry not cleared by mul or div");

  property p_da_carry;
    s_op(pswf_pkg::PSWF_OP_DA) ##0 (o_carry_flag || i_op_a > 8'h99)
      |=> o_carry_flag;
  endproperty
  a_da_carry: assert property (p_da_carry) // [RULE3]
    else $error("decimal adjust lost carry");

  property p_cjne_carry;
    s_op(pswf_pkg::PSWF_OP_CJNE) |=>
      o_carry_flag == ($past(i_op_a) < $past(i_op_b));
  endproperty
  a_cjne_carry: assert property (p_cjne_carry) // [RULE4]
    else $error("carry wrong after compare");

  property p_add_half;
    s_op(pswf_pkg::PSWF_OP_ADD) |=> o_half_carry_flag ==
      (({1'b0, $past(i_op_a[3:0])} + {1'b0, $past(i_op_b[3:0])}) > 5'h0F);
  endproperty
  a_add_half: assert property (p_add_half) // [RULE5]
    else $error("half carry wrong after add");

  property p_user_hold;
    s_no_write |=> $stable(o_user_flag_zero) && $stable(o_user_flag_one);
  endproperty
  a_user_hold: assert property (p_user_hold) // [RULE6]
    else $error("user flag changed without write");

  property p_bank_addr;
    1'b1 |=> o_ram_addr == {3'h0, $past(o_bank_select_hi),
                            $past(o_bank_select_lo), $past(i_reg_idx)};
  endproperty
  a_bank_addr: assert property (p_bank_addr) // [RULE7]
    else $error("bank address wrong");

  property p_add_wrap;
    s_op(pswf_pkg::PSWF_OP_ADD) |=> o_signed_wrap_flag ==
      (($past(i_op_a[7]) == $past(i_op_b[7])) &&
       ($past(sum9[7]) != $past(i_op_a[7])));
  endproperty
  a_add_wrap: assert property (p_add_wrap) // [RULE8]
    else $error("signed wrap wrong after add");

  property p_subb_wrap;
    s_op(pswf_pkg::PSWF_OP_SUBB) |=> o_signed_wrap_flag ==
      (($past(i_op_a[7]) != $past(i_op_b[7])) &&
       ($past(dif9[7]) != $past(i_op_a[7])));
  endproperty
  a_subb_wrap: assert property (p_subb_wrap) // [RULE9]
    else $error("signed wrap wrong after subtract");

  property p_mul_wrap;
    s_op(pswf_pkg::PSWF_OP_MUL) |=>
      o_signed_wrap_flag ==
      (({8'h00, $past(i_op_a)} * {8'h00, $past(i_op_b)}) > 16'h00FF);
  endproperty
  a_mul_wrap: assert property (p_mul_wrap) // [RULE10]
    else $error("signed wrap wrong after mul");

  property p_div_wrap;
    s_op(pswf_pkg::PSWF_OP_DIV) |=>
      o_signed_wrap_flag == ($past(i_op_b) == 8'h00);
  endproperty
  a_div_wrap: assert property (p_div_wrap) // [RULE11]
    else $error("signed wrap wrong after div");

  property p_parity;
    1'b1 |=> o_parity == ^$past(i_acc);
  endproperty
  a_parity: assert property (p_parity) // [RULE12]
    else $error("parity does not follow accumulator");

  property p_reset_zero;
    disable iff (1'b0) !i_rstn |=> (status_word == 8'h00) && !o_pready;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // [RULE13]
    else $error("status word not zero after reset");

  property p_write_all;
    apb_wr && !i_bit_we && !i_op_valid |=>
      status_word[7:1] == $past(i_pwdata[7:1]);
  endproperty
  a_write_all: assert property (p_write_all) // [RULE14]
    else $error("software write not taken");

endmodule : pswf_status_word

// [program_status_flags_test.sv]
`timescale 1ns/1ps
module program_status_flags_test;
  logic               i_clk;
  logic               i_rstn;
  logic               i_psel;
  logic               i_penable;
  logic               i_pwrite;
  logic [11:0]        i_paddr;
  logic [31:0]        i_pwdata;
  logic [3:0]         i_pstrb;
  logic [31:0]        o_prdata;
  logic               o_pready;
  logic               o_pslverr;
  logic               i_op_valid;
  pswf_pkg::pswf_op_t i_op_kind;
  logic [7:0]         i_op_a;
  logic [7:0]         i_op_b;
  logic               i_bit_we;
  logic [2:0]         i_bit_sel;
  logic               i_bit_val;
  logic [7:0]         i_acc;
  logic [2:0]         i_reg_idx;
  wire  [7:0]         o_flags;
  logic [7:0]         o_ram_addr;
  logic [7:0]         es;
  logic               par_exp;
  logic [7:0]         ram_exp;
  logic [31:0]        r1;
  logic [31:0]        r2;
  logic [18:0]        tbl [16];
  int                 n_mismatch;
  int                 checks;
  int                 seed;
  int                 cycles;

  pswf_status_word uut
  (
    .i_clk              (i_clk),
    .i_rstn             (i_rstn),
    .i_psel             (i_psel),
    .i_penable          (i_penable),
    .i_pwrite           (i_pwrite),
    .i_paddr            (i_paddr),
    .i_pwdata           (i_pwdata),
    .i_pstrb            (i_pstrb),
    .o_prdata           (o_prdata),
    .o_pready           (o_pready),
    .o_pslverr          (o_pslverr),
    .i_op_valid         (i_op_valid),
    .i_op_kind          (i_op_kind),
    .i_op_a             (i_op_a),
    .i_op_b             (i_op_b),
    .i_bit_we           (i_bit_we),
    .i_bit_sel          (i_bit_sel),
    .i_bit_val          (i_bit_val),
    .i_acc              (i_acc),
    .i_reg_idx          (i_reg_idx),
    .o_carry_flag       (o_flags[7]),
    .o_half_carry_flag  (o_flags[6]),
    .o_user_flag_zero   (o_flags[5]),
    .o_bank_select_hi   (o_flags[4]),
    .o_bank_select_lo   (o_flags[3]),
    .o_signed_wrap_flag (o_flags[2]),
    .o_user_flag_one    (o_flags[1]),
    .o_parity           (o_flags[0]),
    .o_ram_addr         (o_ram_addr)
  );

  always #2 i_clk = ~i_clk;

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  // flags after an instruction; w already holds the bit write
  function automatic logic [7:0] next_flags(input logic [7:0] s,
      input logic [7:0] w, input pswf_pkg::pswf_op_t k,
      input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    logic [7:0] l;
    logic [4:0] h;
    logic       c;
    c = s[7] & (k != pswf_pkg::PSWF_OP_ADD);
    t = {1'b0, a} + {1'b0, b} + 9'(c);
    l = {1'b0, a[6:0]} + {1'b0, b[6:0]} + 8'(c);
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(c);
    if (k == pswf_pkg::PSWF_OP_SUBB)
    begin
      t = {1'b0, a} - {1'b0, b} - 9'(c);
      l = {1'b0, a[6:0]} - {1'b0, b[6:0]} - 8'(c);
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(c);
    end
    next_flags = w;
    case (k)
      pswf_pkg::PSWF_OP_ADD, pswf_pkg::PSWF_OP_ADDC, pswf_pkg::PSWF_OP_SUBB:
      begin
        next_flags[7:6] = {t[8], h[4]};
        next_flags[2] = l[7] ^ t[8];
      end
      pswf_pkg::PSWF_OP_MUL:
        next_flags[2:0] = {({8'h00, a} * {8'h00, b}) > 16'h00FF, w[1:0]};
      pswf_pkg::PSWF_OP_DIV:
        next_flags[2:0] = {b == 8'h00, w[1:0]};
      pswf_pkg::PSWF_OP_DA:
      begin
        t = {1'b0, a};
        if (a[3:0] > 4'h9 || s[6])
          t = t + 9'h006;
        c = s[7] | t[8];
        if (t[7:4] > 4'h9 || c)
          t = {1'b0, t[7:0]} + 9'h060;
        next_flags[7] = c | t[8];
      end
      pswf_pkg::PSWF_OP_CJNE:
        next_flags[7] = a < b;
      default:
        next_flags = w;
    endcase
    if (k == pswf_pkg::PSWF_OP_MUL || k == pswf_pkg::PSWF_OP_DIV)
      next_flags[7] = 1'b0;
  endfunction : next_flags

  ////////////////////////////////////////////////////////////
  task automatic step(input logic v, input logic [18:0] op, input logic we,
                      input logic [2:0] sel, input logic val,
                      input logic [7:0] acc, input logic [2:0] idx);
    logic [7:0] n;
    @(posedge i_clk);
    i_op_valid <= v;
    i_op_kind  <= pswf_pkg::pswf_op_t'(op[18:16]);
    i_op_a     <= op[15:8];
    i_op_b     <= op[7:0];
    i_bit_we   <= we;
    i_bit_sel  <= sel;
    i_bit_val  <= val;
    i_acc      <= acc;
    i_reg_idx  <= idx;
    @(negedge i_clk);
    chk(32'(o_flags[7]), 32'(es[7]), "cf");
    chk(32'(o_flags[6]), 32'(es[6]), "half carry");
    chk(32'(o_flags[2]), 32'(es[2]), "w");
    chk(32'(o_flags[5:3]), 32'(es[5:3]), "user bank");
    chk(32'(o_flags[1]), 32'(es[1]), "user one");
    chk(32'(o_flags[0]), 32'(par_exp), "parity");
    chk(32'(o_ram_addr), 32'(ram_exp), "ram addr");
    ram_exp = {3'h0, es[4:3], idx};
    par_exp = ^acc;
    n = es;
    if (we && sel != 3'h0)
      n[sel] = val;
    if (v)
      n = next_flags(es, n, pswf_pkg::pswf_op_t'(op[18:16]),
                     op[15:8], op[7:0]);
    es = n;
  endtask : step

  task automatic apb(input logic wr, input logic [11:0] addr,
                     input logic [31:0] wd, input logic [3:0] st,
                     output logic [31:0] rd, output logic err);
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= addr;
    i_pwdata  <= wd;
    i_pstrb   <= st;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do
      @(posedge i_clk);
    while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic reg_chk(input logic wr, input logic [11:0] addr,
                         input logic [7:0] wd, input logic [3:0] st,
                         input logic [31:0] x_rd, input logic x_err);
    logic [31:0] rd;
    logic        err;
    step(1'b0, 19'h0, 1'b0, 3'h0, 1'b0, i_acc, i_reg_idx);
    apb(wr, addr, {24'hFFFFFF, wd}, st, rd, err);
    if (!wr)
      chk(rd, x_rd, "read data");
    chk(32'(err), 32'(x_err), "slave error");
    @(negedge i_clk);
    chk(32'(o_pready), 32'h0, "ready stands one cycle");
    if (wr && addr == pswf_pkg::PSWF_ADDR_PSW && st[0])
      es = {wd[7:1], 1'b0};
    ram_exp = {3'h0, es[4:3], i_reg_idx};
  endtask : reg_chk

  ////////////////////////////////////////////////////////////
  initial
  begin
    {i_clk, i_rstn, i_psel, i_penable, i_pwrite, i_paddr} = '0;
    {i_pwdata, i_pstrb, i_op_valid, i_op_a, i_op_b} = '0;
    {i_bit_we, i_bit_sel, i_bit_val, i_acc, i_reg_idx} = '0;
    i_op_kind = pswf_pkg::PSWF_OP_NONE;
    {es, par_exp, ram_exp, n_mismatch, checks, cycles} = '0;
    seed = 32'h21C0;
    tbl = '{19'h17F01, 19'h1FF01, 19'h30F00, 19'h28001, 19'h20001,
            19'h27FFF, 19'h60F11, 19'h61010, 19'h70500, 19'h70903,
            19'h59A00, 19'h53C00, 19'h40102, 19'h40202, 19'h00000,
            19'h59900};
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    step(1'b0, 19'h0, 1'b0, 3'h0, 1'b0, 8'h03, 3'h5);
    chk(32'(o_flags), 32'h0, "reset value");
    reg_chk(1'b0, 12'h0D0, 8'h00, 4'hF, 32'h0, 1'b0);
    reg_chk(1'b1, 12'h0D0, 8'hFF, 4'hF, 32'h0, 1'b0);
    reg_chk(1'b0, 12'h0D0, 8'h00, 4'hF, 32'hFE, 1'b0);
    reg_chk(1'b1, 12'h0D0, 8'h00, 4'hE, 32'h0, 1'b0);
    reg_chk(1'b1, 12'h0D4, 8'h00, 4'hF, 32'h0, 1'b1);
    reg_chk(1'b0, 12'h0D4, 8'h00, 4'hF, 32'h0, 1'b1);
    step(1'b0, 19'h0, 1'b0, 3'h0, 1'b0, 8'h01, 3'h2);
    reg_chk(1'b0, 12'h0D0, 8'h00, 4'hF, 32'hFF, 1'b0);
    reg_chk(1'b1, 12'h0D0, 8'h00, 4'hF, 32'h0, 1'b0);
    foreach (tbl[i])
      step(1'b1, tbl[i], 1'b0, 3'h0, 1'b0, tbl[i][15:8], 3'(i));
    repeat (3000)
    begin
      r1 = $random(seed);
      r2 = $random(seed);
      if (r1[16:14] == 3'h0)
        r2[7:0] = 8'h00;
      step(r1[0] | r1[1], {r1[4:2], r2[15:0]}, r1[5] & r1[6], r1[9:7],
           r1[10], r2[23:16], r1[13:11]);
    end
    @(posedge i_clk);
    {i_op_valid, i_bit_we, i_acc, i_reg_idx} <= '0;
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    {es, par_exp, ram_exp} = '0;
    step(1'b0, 19'h0, 1'b0, 3'h0, 1'b0, 8'h00, 3'h0);
    chk(32'(o_flags), 32'h0, "second reset");
    give_verdict();
  end
endmodule : program_status_flags_test
